/* File: rtl/bac_pkg.sv */
// Purpose: Shared constants and carrier types for buffer admission
// Assumes: One frame occupies one buffer slot
// Notes: Counter widths sized for the largest slot pool
package bac_pkg;

   // ****************************************
   // Sizes
   // ****************************************
   localparam int NPORT = 8;
   localparam int NCLS = 8;
   localparam int NVLAN = 8;
   localparam int CNT_W = 10;
   localparam int OCC_W = 10;
   localparam int MC_W = 7;
   localparam logic [MC_W-1:0] MC_MAX = 7'h40;
   localparam logic [2:0] CLS_RES_LO = 3'h2;
   localparam logic [2:0] CLS_BEST = 3'h0;
   // Fixed queue level at which a port counts as congested
   localparam logic [OCC_W-1:0] CONG_THR = 10'h020;

   // ****************************************
   // Carriers
   // ****************************************
   typedef enum logic [1:0] {RG_CLASS, RG_PORT, RG_SHARED, RG_NONE} bac_region_t;

   typedef struct packed {
      logic [2:0] src;
      logic [2:0] cls;
      logic mcast;
      logic [NPORT-1:0] fanout;
      logic [2:0] vlan;
   } bac_req_t;

   typedef struct packed {
      logic [2:0] src;
      logic [2:0] cls;
      bac_region_t rg;
      logic mcast;
      logic [2:0] vlan;
   } bac_rel_t;

   typedef struct packed {
      logic admit;
      logic [2:0] queue;
      bac_region_t rg;
   } bac_dec_t;

endpackage : bac_pkg

/* File: rtl/bac_admit.sv */
// Purpose: Frame slot admission and Xoff/Xon flow control
// Assumes: Classify and release pulses name frames already held
// Notes: Pause frame generation lives in the MAC
//
// Summary of operation
// R1: Hold arrivals in temporary region until classified
// R2: Reserve slots for classes two to seven
// R3: Separate slot reservation per source port
// R4: Shared pool takes any class, any port
// R5: Drop only when no space is left
// R6: Flow control enabled per source port
// R7: Flow-controlled frames go to lowest queue
// R8: Flow-controlled frames skip class reservations
// R9: Global option restores normal class handling
// R10: Unicast Xoff at programmed reserved-slot use
// R11: Unicast Xon once reserved slots all free
// R12: Multicast counter threshold drives Xoff and Xon
// R13: Per-VLAN multicast counters in VLAN mode
// R14: Congested fan-out map gates multicast Xon
// R15: Port congested while occupancy at or above threshold
// R16: Option disables multicast flow control
// R17: Class seven management, six expedited, zero-one best
// R18: Best effort served only when others idle
// R19: Priority and best effort dropped only globally
// R20: Xoff and Xon become pause frames
// R21: Charge reservation first, shared pool last
`timescale 1ns/1ps
`default_nettype none
module bac_admit
   import bac_pkg::*;
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // Arrival into temporary region
   input wire logic arrive_in,
   output logic arrive_ok_out,
   // Classification and decision
   input wire logic classify_in,
   input wire bac_req_t req_in,
   output logic dec_valid_out,
   output bac_dec_t dec_out,
   // Slot release
   input wire logic release_in,
   input wire bac_rel_t rel_in,
   // Configuration
   input wire logic [CNT_W-1:0] temp_size_in,
   input wire logic [NCLS-1:0][CNT_W-1:0] class_reservation_size_in,
   input wire logic [NPORT-1:0][CNT_W-1:0] source_port_reservation_size_in,
   input wire logic [CNT_W-1:0] shared_pool_size_in,
   input wire logic [NPORT-1:0][CNT_W-1:0] unicast_xoff_level_in,
   input wire logic [NPORT-1:0] fc_enable_in,
   input wire logic fc_qos_normal_in,
   input wire logic [MC_W-1:0] multicast_hold_threshold_in,
   input wire logic vlan_mode_in,
   input wire logic mcast_fc_disable_in,
   // Egress queue state
   input wire logic [NPORT-1:0][OCC_W-1:0] occupancy_in,
   input wire logic [NPORT-1:0] hi_busy_in,
   // Flow control and status
   output logic [NPORT-1:0] xoff_out,
   output logic [NPORT-1:0] pause_out,
   output logic [NPORT-1:0] resume_out,
   output logic [NPORT-1:0] be_serve_out,
   output logic [NPORT-1:0] congested_out,
   output logic [CNT_W-1:0] temp_used_out,
   output logic [CNT_W-1:0] shared_used_out
);

   // ****************************************
   // State
   // ****************************************
   logic [CNT_W-1:0] temp_reg, temp_next, sh_reg, sh_next;
   logic [NCLS-1:0][CNT_W-1:0] cu_reg, cu_next;
   logic [NPORT-1:0][CNT_W-1:0] pu_reg, pu_next;
   logic [NVLAN-1:0][MC_W-1:0] mc_reg, mc_next;
   logic [NPORT-1:0] xu_reg, xu_next, xm_reg, xm_next;
   logic [NPORT-1:0][NPORT-1:0] map_reg, map_next;
   logic [NPORT-1:0][2:0] vl_reg, vl_next;
   logic [NPORT-1:0] xoff_reg, xoff_next, pause_reg, pause_next;
   logic [NPORT-1:0] resume_reg, resume_next;
   bac_dec_t dec_reg, dec_next;
   logic dec_valid_reg, dec_valid_next;
   logic [2:0] eq, ai, ri;
   bac_region_t rg;
   logic take, adm, clr;
   logic [NPORT-1:0] cong;

   // ****************************************
   // Admission decision
   // ****************************************
   // Queue choice and region charge for a classified frame
   always_comb
   begin
      eq = req_in.cls;
      if (fc_enable_in[req_in.src] && !fc_qos_normal_in) // R6 R9
      begin
         eq = CLS_BEST; // R7 R18
      end
      rg = RG_NONE; // R5 R19
      if (eq >= CLS_RES_LO && cu_reg[eq] < class_reservation_size_in[eq])
      begin
         rg = RG_CLASS; // R2 R8 R17 R21
      end
      else if (pu_reg[req_in.src] < source_port_reservation_size_in[req_in.src])
      begin
         rg = RG_PORT; // R3 R21
      end
      else if (sh_reg < shared_pool_size_in)
      begin
         rg = RG_SHARED; // R4
      end
      dec_next.admit = (rg != RG_NONE);
      dec_next.queue = eq;
      dec_next.rg = rg;
      dec_valid_next = classify_in; // R1
      adm = classify_in && (rg != RG_NONE);
   end

   // ****************************************
   // Slot counters
   // ****************************************
   // Temporary, class, port, shared and multicast occupancy
   always_comb
   begin
      take = arrive_in && arrive_ok_out;
      ai = vlan_mode_in ? req_in.vlan : 3'h0; // R13
      ri = vlan_mode_in ? rel_in.vlan : 3'h0;
      temp_next = temp_reg + CNT_W'(take) - CNT_W'(classify_in && temp_reg != '0); // R1
      sh_next = sh_reg + CNT_W'(adm && rg == RG_SHARED)
         - CNT_W'(release_in && rel_in.rg == RG_SHARED && sh_reg != '0);
      for (int c = 0; c < NCLS; c++)
      begin
         cu_next[c] = cu_reg[c] + CNT_W'(adm && rg == RG_CLASS && eq == c)
            - CNT_W'(release_in && rel_in.rg == RG_CLASS && rel_in.cls == c && cu_reg[c] != '0);
      end
      for (int p = 0; p < NPORT; p++)
      begin
         pu_next[p] = pu_reg[p] + CNT_W'(adm && rg == RG_PORT && req_in.src == p)
            - CNT_W'(release_in && rel_in.rg == RG_PORT && rel_in.src == p && pu_reg[p] != '0);
      end
      for (int v = 0; v < NVLAN; v++)
      begin
         mc_next[v] = mc_reg[v] + MC_W'(adm && req_in.mcast && ai == v && mc_reg[v] < MC_MAX)
            - MC_W'(release_in && rel_in.mcast && ri == v && mc_reg[v] != '0); // R12 R13
      end
   end

   // ****************************************
   // Flow control
   // ****************************************
   // Unicast and multicast Xoff/Xon per source port
   always_comb
   begin
      clr = 1'b0;
      for (int q = 0; q < NPORT; q++)
      begin
         cong[q] = occupancy_in[q] >= CONG_THR; // R15
      end
      for (int p = 0; p < NPORT; p++)
      begin
         // Unicast: set wins over release to zero
         xu_next[p] = (fc_enable_in[p] && unicast_xoff_level_in[p] != '0
            && pu_reg[p] >= unicast_xoff_level_in[p]) // R10
            || (xu_reg[p] && pu_reg[p] != '0); // R11
         clr = mcast_fc_disable_in || (((map_reg[p] & cong) == '0)
            && mc_reg[vl_reg[p]] <= multicast_hold_threshold_in); // R12 R14 R16
         xm_next[p] = xm_reg[p] && !clr;
         map_next[p] = clr ? '0 : map_reg[p]; // R14
         vl_next[p] = vl_reg[p];
         if (adm && req_in.mcast && req_in.src == p && fc_enable_in[p] && !mcast_fc_disable_in
            && mc_reg[ai] > multicast_hold_threshold_in) // R12 R16
         begin
            xm_next[p] = 1'b1;
            map_next[p] = (clr ? '0 : map_reg[p]) | (req_in.fanout & cong); // R14
            vl_next[p] = ai;
         end
      end
      xoff_next = xu_next | xm_next;
      pause_next = xoff_next & ~xoff_reg; // R20
      resume_next = ~xoff_next & xoff_reg; // R20
   end

   // ****************************************
   // Registers
   // ****************************************
   // All state on one clock, cleared by reset except decision region, which reset sets to RG_NONE
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         temp_reg <= '0;
         sh_reg <= '0;
         cu_reg <= '0;
         pu_reg <= '0;
         mc_reg <= '0;
         xu_reg <= '0;
         xm_reg <= '0;
         map_reg <= '0;
         vl_reg <= '0;
         xoff_reg <= '0;
         pause_reg <= '0;
         resume_reg <= '0;
         dec_reg <= '{admit: 1'b0, queue: 3'h0, rg: RG_NONE};
         dec_valid_reg <= 1'b0;
      end
      else
      begin
         temp_reg <= temp_next;
         sh_reg <= sh_next;
         cu_reg <= cu_next;
         pu_reg <= pu_next;
         mc_reg <= mc_next;
         xu_reg <= xu_next;
         xm_reg <= xm_next;
         map_reg <= map_next;
         vl_reg <= vl_next;
         xoff_reg <= xoff_next;
         pause_reg <= pause_next;
         resume_reg <= resume_next;
         dec_reg <= dec_next;
         dec_valid_reg <= dec_valid_next;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   // Temporary room, decisions, flow control, status
   assign arrive_ok_out = temp_reg < temp_size_in; // R1
   assign dec_valid_out = dec_valid_reg;
   assign dec_out = dec_reg;
   assign xoff_out = xoff_reg;
   assign pause_out = pause_reg;
   assign resume_out = resume_reg;
   assign be_serve_out = ~hi_busy_in; // R18
   assign congested_out = cong;
   assign temp_used_out = temp_reg;
   assign shared_used_out = sh_reg;

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (rst_in);

   sequence fc_frame_s;
      classify_in && fc_enable_in[req_in.src] && !fc_qos_normal_in;
   endsequence

   temp_full_a: assert property (arrive_in && !arrive_ok_out && !classify_in |=> temp_reg == $past(temp_reg)) // R1
      else $error("temp region grew while full");
   class_low_a: assert property (dec_valid_out && dec_out.rg == RG_CLASS |-> dec_out.queue >= CLS_RES_LO) // R2
      else $error("class reservation charged for low class");
   fc_queue_a: assert property (fc_frame_s |=> dec_valid_out && dec_out.queue == CLS_BEST) // R7
      else $error("flow-controlled frame not in lowest queue");
   fc_noclass_a: assert property (fc_frame_s |=> dec_out.rg != RG_CLASS) // R8
      else $error("flow-controlled frame used class reservation");
   charge_order_a: assert property (classify_in && eq >= CLS_RES_LO
      && cu_reg[eq] < class_reservation_size_in[eq] |=> dec_out.rg == RG_CLASS) // R21
      else $error("class reservation skipped");
   no_drop_a: assert property (classify_in && sh_reg < shared_pool_size_in |=> dec_out.admit) // R5
      else $error("frame dropped with shared space free");
   mc_off_a: assert property (mcast_fc_disable_in |=> xm_reg == '0) // R16
      else $error("multicast Xoff while disabled");
   mc_cap_a: assert property (mc_reg[0] <= MC_MAX) // R12
      else $error("multicast counter beyond limit");

   // Admitted multicast frame above its counter threshold
   sequence mc_hot_s;
      adm && req_in.mcast && !mcast_fc_disable_in && mc_reg[ai] > multicast_hold_threshold_in;
   endsequence

   temp_take_a: assert property (take && !classify_in |=> temp_reg == $past(temp_reg) + CNT_W'(1)) // R1
      else $error("accepted arrival not counted");
   dec_idle_a: assert property (!classify_in |=> !dec_valid_out) // R1
      else $error("decision without classify");

   for (genvar p = 0; p < NPORT; p++)
   begin : g_chk
      uc_xoff_a: assert property (fc_enable_in[p] && unicast_xoff_level_in[p] != '0
         && pu_reg[p] >= unicast_xoff_level_in[p] |=> xu_reg[p] && xoff_reg[p]) // R10
         else $error("unicast Xoff missing");
      uc_xon_a: assert property ($fell(xu_reg[p]) |-> $past(pu_reg[p]) == '0) // R11
         else $error("unicast Xon with slots held");
      pause_pulse_a: assert property ($rose(xoff_reg[p]) |-> pause_out[p] ##1 !pause_out[p]) // R20
         else $error("pause pulse wrong");
      resume_pulse_a: assert property ($fell(xoff_reg[p]) |-> resume_out[p] ##1 !resume_out[p]) // R20
         else $error("resume pulse wrong");
      uc_hold_a: assert property (xu_reg[p] && pu_reg[p] != '0 |=> xu_reg[p]) // R11
         else $error("unicast Xoff dropped early");

      // Multicast hold and release per port
      mc_xoff_a: assert property (mc_hot_s ##0 (req_in.src == p && fc_enable_in[p]) |=> xoff_reg[p]) // R12
         else $error("multicast Xoff missing");
      mc_hold_a: assert property (xm_reg[p] && (map_reg[p] & cong) != '0 // R14
         && !mcast_fc_disable_in |=> xm_reg[p])
         else $error("multicast Xon with congested port");
      mc_map_a: assert property ($fell(xm_reg[p]) |-> map_reg[p] == '0) // R14
         else $error("congestion map kept after Xon");
   end

endmodule : bac_admit
`default_nettype wire

/* File: dv/bac_far_model.sv */
// Purpose: Egress scheduler and link partner stand-in
// Assumes: Bench sets queue levels through lvl_in and hi_in
// Notes: Pause halts the port until resume arrives
`timescale 1ns/1ps
`default_nettype none
module bac_far_model
   import bac_pkg::*;
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // Requested queue state
   input wire logic [NPORT-1:0][OCC_W-1:0] lvl_in,
   input wire logic [NPORT-1:0] hi_in,
   // Pause frames from the switch
   input wire logic [NPORT-1:0] pause_in,
   input wire logic [NPORT-1:0] resume_in,
   // Reported state
   output logic [NPORT-1:0][OCC_W-1:0] occ_out,
   output logic [NPORT-1:0] hi_busy_out,
   output logic [NPORT-1:0] halted_out
);
   // Queue levels and sender hold state
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         occ_out <= '0;
         hi_busy_out <= '0;
         halted_out <= '0;
      end
      else
      begin
         occ_out <= lvl_in;
         hi_busy_out <= hi_in;
         halted_out <= (halted_out | pause_in) & ~resume_in;
      end
   end
endmodule : bac_far_model
`default_nettype wire

/* File: dv/buffer_admission_flow_control_tb.sv */
// Purpose: Directed bench for buffer admission and flow control
// Assumes: Decision pulse one cycle after classify
// Notes: Small reservations so each region fills in one frame, except port 2 reservation of four and temporary region of two
`timescale 1ns/1ps
`default_nettype none
module buffer_admission_flow_control_tb
   import bac_pkg::*;
;
   // ****************************************
   // Signals
   // ****************************************
   logic clk_in = 0, rst_in = 1, arrive_in = 0, classify_in = 0, release_in = 0;
   logic arrive_ok_out, dec_valid_out, fc_qos_normal_in = 0;
   bac_req_t req_in = '0;
   bac_rel_t rel_in = '0;
   bac_dec_t dec_out;
   logic [NCLS-1:0][CNT_W-1:0] cls_res = {NCLS{10'h0001}};
   logic [NPORT-1:0][CNT_W-1:0] port_res = {{5{10'h0001}}, 10'h0004, 10'h0001, 10'h0001};
   logic [NPORT-1:0][CNT_W-1:0] xlvl = {{5{10'h0000}}, 10'h0002, 10'h0000, 10'h0000};
   logic [NPORT-1:0][OCC_W-1:0] lvl = '0, occ;
   logic [NPORT-1:0] hi = '0, hib, halted, xoff_out, pause_out, resume_out, be_serve_out, congested_out;
   logic [CNT_W-1:0] temp_used_out, shared_used_out;
   int error_cnt = 0, compares = 0, cyc = 0;
   logic mdis = 0, vmode = 0;
   logic [MC_W-1:0] mthr = 7'h10;
   logic [NPORT-1:0] fan = '0;
   logic [2:0] vl = '0;

   // Clock and timeout
   always #12.5 clk_in = ~clk_in;
   always @(posedge clk_in)
   begin
      cyc <= cyc + 1;
      if (cyc == 3000)
      begin
         error_cnt = error_cnt + 1;
         conclude();
      end
   end

   bac_admit u_dut (.clk_in(clk_in), .rst_in(rst_in), .arrive_in(arrive_in), .arrive_ok_out(arrive_ok_out),
      .classify_in(classify_in), .req_in(req_in), .dec_valid_out(dec_valid_out), .dec_out(dec_out),
      .release_in(release_in), .rel_in(rel_in), .temp_size_in(10'h0002), .class_reservation_size_in(cls_res),
      .source_port_reservation_size_in(port_res), .shared_pool_size_in(10'h0001),
      .unicast_xoff_level_in(xlvl), .fc_enable_in(8'h04), .fc_qos_normal_in(fc_qos_normal_in),
      .multicast_hold_threshold_in(mthr), .vlan_mode_in(vmode), .mcast_fc_disable_in(mdis),
      .occupancy_in(occ), .hi_busy_in(hib), .xoff_out(xoff_out), .pause_out(pause_out),
      .resume_out(resume_out), .be_serve_out(be_serve_out), .congested_out(congested_out),
      .temp_used_out(temp_used_out), .shared_used_out(shared_used_out));

   bac_far_model u_far (.clk_in(clk_in), .rst_in(rst_in), .lvl_in(lvl), .hi_in(hi), .pause_in(pause_out),
      .resume_in(resume_out), .occ_out(occ), .hi_busy_out(hib), .halted_out(halted));

   // ****************************************
   // Tasks
   // ****************************************
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      compares = compares + 1;
      if (exp !== got)
      begin
         error_cnt = error_cnt + 1;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   // Arrival, classify, then check the decision
   task automatic frame(input logic [2:0] s, input logic [2:0] c, input logic a, input logic [2:0] q,
      input bac_region_t rg);
      @(posedge clk_in) arrive_in <= 1;
      @(posedge clk_in) arrive_in <= 0;
      classify_in <= 1;
      req_in <= '{src: s, cls: c, mcast: |fan, fanout: fan, vlan: vl};
      @(posedge clk_in) classify_in <= 0;
      #1;
      chk("dec_valid", 1, dec_valid_out);
      chk("adm_rg", {a, rg}, {dec_out.admit, dec_out.rg});
      if (a)
         chk("queue", q, dec_out.queue);
      chk("temp_used", 0, temp_used_out);
   endtask : frame

   task automatic rel(input logic [2:0] s, input logic [2:0] c, input bac_region_t rg);
      @(posedge clk_in) release_in <= 1;
      rel_in <= '{src: s, cls: c, rg: rg, mcast: 1'b0, vlan: 3'h0};
      @(posedge clk_in) release_in <= 0;
   endtask : rel

   task automatic wait_xoff(input logic v);
      for (int i = 0; i < 8 && xoff_out[2] !== v; i++)
         @(posedge clk_in);
      #1;
   endtask : wait_xoff

   task automatic conclude();
      $display("errors %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : conclude

   // ****************************************
   // Tests
   // ****************************************
   initial
   begin
      repeat (2) @(posedge clk_in);
      rst_in <= 0;
      #1;
      chk("rst_dec", {1'b0, RG_NONE}, {dec_out.admit, dec_out.rg});
      chk("rst_xoff", 0, xoff_out);
      frame(0, 7, 1, 7, RG_CLASS);
      frame(0, 7, 1, 7, RG_PORT);
      frame(0, 7, 1, 7, RG_SHARED);
      chk("shared_used", 1, shared_used_out);
      frame(0, 7, 0, 0, RG_NONE);
      frame(1, 0, 1, 0, RG_PORT);
      rel(0, 7, RG_CLASS);
      frame(2, 7, 1, 0, RG_PORT);
      frame(2, 6, 1, 0, RG_PORT);
      wait_xoff(1);
      chk("xoff_set", 1, xoff_out[2]);
      chk("halted", 1, halted[2]);
      fc_qos_normal_in <= 1;
      frame(2, 7, 1, 7, RG_CLASS);
      rel(2, 0, RG_PORT);
      repeat (3) @(posedge clk_in);
      chk("xoff_hold", 1, xoff_out[2]);
      rel(2, 0, RG_PORT);
      wait_xoff(0);
      chk("xoff_clr", 0, xoff_out[2]);
      chk("halted", 0, halted[2]);
      lvl[5] <= 10'h0020;
      lvl[4] <= 10'h001f;
      hi <= 8'h01;
      repeat (2) @(posedge clk_in);
      #1;
      chk("congested", 16'h0020, congested_out);
      chk("be_serve", 16'h00fe, be_serve_out);
      // Multicast: disabled, per-VLAN counter, then map-gated Xon
      mthr <= 7'h00;
      mdis <= 1;
      fan <= 8'h30;
      frame(2, 3, 1, 3, RG_CLASS);
      frame(2, 4, 1, 4, RG_CLASS);
      chk("mc_dis", 0, xoff_out[2]);
      mdis <= 0;
      vmode <= 1;
      vl <= 3'h1;
      frame(2, 5, 1, 5, RG_CLASS);
      chk("mc_vlan", 0, xoff_out[2]);
      vmode <= 0;
      frame(2, 6, 1, 6, RG_CLASS);
      chk("mc_xoff", 1, xoff_out[2]);
      mthr <= 7'h03;
      repeat (2) @(posedge clk_in);
      #1;
      chk("mc_hold", 1, xoff_out[2]);
      lvl[5] <= 10'h0000;
      wait_xoff(0);
      chk("mc_xon", 0, xoff_out[2]);
      // Temporary region fills and refuses a third arrival
      @(posedge clk_in) arrive_in <= 1;
      repeat (3) @(posedge clk_in);
      arrive_in <= 0;
      #1;
      chk("arrive_ok", 0, arrive_ok_out);
      chk("temp_full", 2, temp_used_out);
      conclude();
   end
endmodule : buffer_admission_flow_control_tb
`default_nettype wire
